// *** chip_select_wait_state_decoder.sv ***
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - direction bit 0 reads only, 1 writes only
// - direction bits reset to zero, read only
// - direction_ignore_ctl 0 ignores direction; resets 0
// - write to read-only region flags, optional error
// - disabled select never asserts; enabled decodes
// - after reset only select 0 enabled
// - disabled-processor reset disables all four selects
// - parameters change while select stays enabled
// - ack code 0..6 waits, 111 external
// - external code: device leaves acknowledge undriven
// - ack field resets to six waits
// - waits counted on internal clock, all masters
// - zero waits: acknowledge together with select
// - mask bit 0 don't care, 1 must match
// - mask bits reset to ones, 8K boot block
// - space_compare_on 0 skips space check; resets 1
// - space code 111 never asserts any select
// - only address bits 23..13 compared
// - read-only write flags, select stays off
// - overlap: lowest numbered select wins
// - extra wait for outside master when set
module chip_select_wait_state_decoder (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// strap sampled during reset
	input wire logic cpu_disabled_mode,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// bus cycle from the masters
	input wire cs_pkg::cycle_t cycle,
	input wire logic ext_ack_in,
	// towards memories and masters
	output logic [3:0] select_n,
	output logic ack_out,
	output logic ack_oe,
	output logic berr_out
);
	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [15:0] base_ff [cs_pkg::num_sel];
	logic [15:0] option_ff [cs_pkg::num_sel];
	logic err_on_ff;
	logic extra_wait_ff;
	logic violation_ff;

	// ----------------------------------------
	// axi4-lite slave state
	// ----------------------------------------
	logic aw_held_ff;
	logic w_held_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;

	// ----------------------------------------
	// decoder state
	// ----------------------------------------
	cs_pkg::state_t state_ff;
	cs_pkg::state_t nxt_state;
	logic [3:0] select_n_ff;
	logic ack_ff;
	logic ack_oe_ff;
	logic berr_ff;
	logic [3:0] wait_ff;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	wire aw_take = awvalid && !aw_held_ff;
	wire w_take = wvalid && !w_held_ff;
	wire do_write = aw_held_ff && w_held_ff && !bvalid_ff;
	wire [3:0] wr_idx = aw_addr_ff[5:2];
	wire wr_base = (aw_addr_ff[7:5] == 3'b000) && (aw_addr_ff[4] == 1'b0);
	wire wr_option = (aw_addr_ff[7:5] == 3'b000) && (aw_addr_ff[4] == 1'b1);
	wire wr_ctl = (aw_addr_ff == cs_pkg::ctl_off);
	wire wr_stat = (aw_addr_ff == cs_pkg::stat_off);
	wire wr_hit = wr_base || wr_option || wr_ctl || wr_stat;
	wire [1:0] wr_sel = wr_idx[1:0];
	wire [15:0] wr_mask = {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	wire ar_take = arvalid && !rvalid_ff;
	wire [1:0] rd_sel = araddr[3:2];
	wire rd_base = (araddr[7:5] == 3'b000) && (araddr[4] == 1'b0);
	wire rd_option = (araddr[7:5] == 3'b000) && (araddr[4] == 1'b1);
	wire rd_ctl = (araddr == cs_pkg::ctl_off);
	wire rd_stat = (araddr == cs_pkg::stat_off);
	wire rd_hit = rd_base || rd_option || rd_ctl || rd_stat;
	wire [15:0] rd_word = rd_base ? base_ff[rd_sel] :
		rd_option ? option_ff[rd_sel] :
		rd_ctl ? {14'h0000, extra_wait_ff, err_on_ff} :
		rd_stat ? {15'h0000, violation_ff} : 16'h0000;

	// ----------------------------------------
	// per-select match, one generate loop
	// ----------------------------------------
	wire idle_start = (state_ff == cs_pkg::st_idle) && cycle.strobe;
	wire space_ok = (cycle.space != cs_pkg::space_never);
	logic [3:0] region_hit;
	logic [3:0] dir_bad;
	logic [3:0] grant_hit;

	genvar g;
	generate
		for (g = 0; g < cs_pkg::num_sel; g++) begin : g_sel
			wire [10:0] base_a = base_ff[g][cs_pkg::fld_addr_hi:cs_pkg::fld_addr_lo];
			wire [10:0] mask_a = option_ff[g][cs_pkg::fld_addr_hi:cs_pkg::fld_addr_lo];
			// only a23..a13 take part, masked bits are don't care
			wire addr_ok = ((cycle.addr[23:13] ^ base_a) & mask_a) == 11'h000;
			wire fc_ok = !option_ff[g][cs_pkg::fld_en] ||
				(cycle.space == base_ff[g][cs_pkg::fld_space_hi:cs_pkg::fld_space_lo]);
			wire dir_on = option_ff[g][cs_pkg::fld_dir];
			wire dir_ok = !dir_on || (base_ff[g][cs_pkg::fld_dir] == cycle.write);
			// region matches apart from direction
			assign region_hit[g] = base_ff[g][cs_pkg::fld_en] && addr_ok && fc_ok && space_ok;
			assign grant_hit[g] = region_hit[g] && dir_ok;
			// write into a read-only region
			assign dir_bad[g] = region_hit[g] && dir_on && !base_ff[g][cs_pkg::fld_dir] &&
				cycle.write;
		end
	endgenerate

	// ----------------------------------------
	// priority: select 0 highest
	// ----------------------------------------
	wire [3:0] pick = grant_hit & (~grant_hit + 4'h1);
	wire [1:0] pick_idx = pick[0] ? 2'd0 : pick[1] ? 2'd1 : pick[2] ? 2'd2 : 2'd3;
	wire [2:0] pick_code = option_ff[pick_idx][cs_pkg::fld_space_hi:cs_pkg::fld_space_lo];
	wire pick_ext = (pick_code == cs_pkg::ack_external);
	wire pick_extra = extra_wait_ff && cycle.outside;
	wire [3:0] pick_waits = {1'b0, pick_code} + {3'b000, pick_extra};
	wire any_pick = |grant_hit;
	wire violation_evt = idle_start && (|dir_bad);

	// ----------------------------------------
	// next decoder state
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			cs_pkg::st_idle: begin
				if (cycle.strobe) begin
					if (any_pick && !pick_ext && (pick_waits != 4'h0)) begin
						nxt_state = cs_pkg::st_wait;
					end else begin
						nxt_state = cs_pkg::st_hold;
					end
				end
			end
			cs_pkg::st_wait: begin
				if (!cycle.strobe) begin
					nxt_state = cs_pkg::st_idle;
				end else if (wait_ff == 4'h1) begin
					nxt_state = cs_pkg::st_hold;
				end
			end
			cs_pkg::st_hold: begin
				if (!cycle.strobe) begin
					nxt_state = cs_pkg::st_idle;
				end
			end
			default: nxt_state = cs_pkg::st_idle;
		endcase
	end

	// ----------------------------------------
	// decoder registers
	// ----------------------------------------
	// waits counted in aclk cycles whoever owns the bus
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= cs_pkg::st_idle;
			select_n_ff <= 4'hf;
			ack_ff <= 1'b0;
			ack_oe_ff <= 1'b0;
			berr_ff <= 1'b0;
			wait_ff <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			if (idle_start) begin
				select_n_ff <= ~pick;
				wait_ff <= pick_waits;
				ack_oe_ff <= any_pick && !pick_ext;
				ack_ff <= any_pick && !pick_ext && (pick_waits == 4'h0);
				berr_ff <= violation_evt && err_on_ff;
			end else if (state_ff == cs_pkg::st_wait && cycle.strobe) begin
				wait_ff <= wait_ff - 4'h1;
				ack_ff <= (wait_ff == 4'h1);
			end else if (!cycle.strobe) begin
				select_n_ff <= 4'hf;
				ack_ff <= 1'b0;
				ack_oe_ff <= 1'b0;
				berr_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// select registers
	// ----------------------------------------
	// writes land at once, even on an enabled select
	generate
		for (g = 0; g < cs_pkg::num_sel; g++) begin : g_reg
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					base_ff[g] <= cs_pkg::base_rst;
					if (g == 0) begin
						base_ff[g][cs_pkg::fld_en] <= !cpu_disabled_mode;
					end
					option_ff[g] <= cs_pkg::option_rst;
				end else if (do_write && wr_sel == 2'(g)) begin
					if (wr_base) begin
						base_ff[g] <= (base_ff[g] & ~wr_mask) | (w_data_ff[15:0] & wr_mask);
					end
					if (wr_option) begin
						option_ff[g] <= (option_ff[g] & ~wr_mask) | (w_data_ff[15:0] & wr_mask);
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// control and status bits
	// ----------------------------------------
	// a new violation beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_on_ff <= 1'b0;
			extra_wait_ff <= 1'b0;
			violation_ff <= 1'b0;
		end else begin
			if (do_write && wr_ctl && w_strb_ff[0]) begin
				err_on_ff <= w_data_ff[cs_pkg::ctl_err_on];
				extra_wait_ff <= w_data_ff[cs_pkg::ctl_extra_wait];
			end
			if (violation_evt) begin
				violation_ff <= 1'b1;
			end else if (do_write && wr_stat && w_strb_ff[0] && w_data_ff[cs_pkg::stat_violation]) begin
				violation_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite write channels
	// ----------------------------------------
	// address and data are held independently, either may come first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= cs_pkg::resp_okay;
		end else begin
			if (aw_take) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= awaddr;
			end
			if (w_take) begin
				w_held_ff <= 1'b1;
				w_data_ff <= wdata;
				w_strb_ff <= wstrb;
			end
			if (do_write) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit ? cs_pkg::resp_okay : cs_pkg::resp_slverr;
			end else if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read channels
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= cs_pkg::resp_okay;
		end else if (ar_take) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= {16'h0000, rd_word};
			rresp_ff <= rd_hit ? cs_pkg::resp_okay : cs_pkg::resp_slverr;
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// each write ready only while its own channel holds nothing, so a stuck response stalls new writes
	assign awready = !aw_held_ff;
	assign wready = !w_held_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = !rvalid_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign select_n = select_n_ff;
	assign ack_out = ack_ff;
	assign ack_oe = ack_oe_ff;
	assign berr_out = berr_ff;
endmodule

// *** chip_select_wait_state_decoder_test.sv ***
`timescale 1ns/100ps
module chip_select_wait_state_decoder_test;
	localparam logic [7:0] b0 = cs_pkg::base_off;
	localparam logic [7:0] o0 = cs_pkg::option_off;
	localparam logic [7:0] ct = cs_pkg::ctl_off;
	localparam logic [7:0] st = cs_pkg::stat_off;
	localparam logic [2:0] pg = 3'h6;
	logic aclk = 1'h0, aresetn = 1'h0, cpu_disabled_mode = 1'h0, go = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid, ack_out, ack_oe, berr_out, ext_ack_in;
	logic busy, err_seen;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic [3:0] wstrb = 4'hf, select_n, sel_seen;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [1:0] bresp, rresp;
	cs_pkg::cycle_t cycle, req = '0;
	int lat, num_errors = 0, checks_done = 0, cycles = 0;
	always #2.5 aclk = ~aclk;
	chip_select_wait_state_decoder i_chip_select_wait_state_decoder (.aclk, .aresetn,
		.cpu_disabled_mode, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
		.rready, .rdata, .rresp, .cycle, .ext_ack_in, .select_n, .ack_out, .ack_oe, .berr_out);
	cs_bus_master i_cs_bus_master (.aclk, .go, .req, .select_n, .ack_out, .ack_oe, .berr_out,
		.cycle, .ext_ack_in, .busy, .sel_seen, .err_seen, .lat);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic rst(input logic dis);
		aresetn <= 1'h0;
		cpu_disabled_mode <= dis;
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
	endtask
	// write: address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1 && cycles < 20000);
		chk(bresp, er);
		bready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er = 2'h0);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1 && cycles < 20000);
		chk(rdata, {16'h0000, e});
		chk(rresp, er);
		rready <= 1'h0;
		@(posedge aclk);
	endtask
	// one bus cycle through the partner, then judge select, latency and error
	task automatic cyc(input logic [2:0] sp, input logic w, input logic [3:0] es, input int el,
		input logic [23:0] a = 24'h00_0000, input logic ee = 1'h0, input logic o = 1'h0);
		req <= '{1'h1, w, o, sp, a};
		go <= 1'h1;
		@(posedge aclk);
		go <= 1'h0;
		do @(posedge aclk); while (busy !== 1'h0 && cycles < 20000);
		chk(sel_seen, es);
		chk(lat, el);
		chk(err_seen, ee);
	endtask
	task t_reset;
		for (int i = 0; i < 4; i++) begin
			rd(b0 + 8'(4 * i), i == 0 ? 16'hc001 : 16'hc000);
			rd(o0 + 8'(4 * i), 16'hdffd);
		end
		rd(st, 16'h0000);
		rd(8'h30, 16'h0000, cs_pkg::resp_slverr);
		wr(8'h30, 16'hffff, cs_pkg::resp_slverr);
	endtask
	task t_boot;
		cyc(pg, 1'h0, 4'he, 7);
		cyc(pg, 1'h1, 4'he, 7, 24'h00_1fff);
		cyc(pg, 1'h0, 4'hf, 15, 24'h00_2000);
		cyc(3'h5, 1'h0, 4'hf, 15);
	endtask
	task t_waits;
		for (int n = 0; n < 8; n++) begin
			wr(o0, {3'(n), 13'h1ffd});
			cyc(pg, 1'h0, 4'he, n < 7 ? n + 1 : 4);
		end
		wr(ct, 16'h0002);
		wr(o0, 16'h5ffd);
		cyc(pg, 1'h0, 4'he, 4, 24'h00_0000, 1'h0, 1'h1);
		cyc(pg, 1'h0, 4'he, 3);
	endtask
	task t_dir;
		wr(ct, 16'h0001);
		wr(o0, 16'h1fff);
		cyc(pg, 1'h0, 4'he, 1);
		cyc(pg, 1'h1, 4'hf, 15, 24'h00_0000, 1'h1);
		rd(st, 16'h0001);
		wr(st, 16'h0001);
		rd(st, 16'h0000);
		wr(b0, 16'hc003);
		cyc(pg, 1'h0, 4'hf, 15);
		cyc(pg, 1'h1, 4'he, 1);
	endtask
	task t_prio;
		wr(b0, 16'hc001);
		wr(o0, 16'h1ffc);
		cyc(3'h5, 1'h1, 4'he, 1);
		cyc(3'h7, 1'h0, 4'hf, 15);
		wr(b0 + 8'h04, 16'hc001);
		wr(o0 + 8'h04, 16'h1ff8);
		cyc(pg, 1'h0, 4'he, 1);
		wr(b0, 16'hc000);
		cyc(pg, 1'h0, 4'hd, 1, 24'h00_2000);
	endtask
	task t_dis;
		rst(1'h1);
		rd(b0, 16'hc000);
		cyc(pg, 1'h0, 4'hf, 15);
	endtask
	task results;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		rst(1'h0);
		t_reset();
		t_boot();
		t_waits();
		t_dir();
		t_prio();
		t_dis();
		results();
	end
	// a hung handshake ends the run as a failure
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end
endmodule

// *** cs_bus_master.sv ***
`timescale 1ns/100ps
module cs_bus_master #(
	parameter int ext_wait = 3
) (
	// clock
	input wire logic aclk,
	// bench request
	input wire logic go,
	input wire cs_pkg::cycle_t req,
	// device answers
	input wire logic [3:0] select_n,
	input wire logic ack_out,
	input wire logic ack_oe,
	input wire logic berr_out,
	// bus lines and results
	output cs_pkg::cycle_t cycle,
	output logic ext_ack_in,
	output logic busy,
	output logic [3:0] sel_seen,
	output logic err_seen,
	output int lat
);
	int cnt;
	initial begin
		cycle = '0;
		ext_ack_in = 1'h0;
		busy = 1'h0;
	end
	// one cycle at a time; a silent bus is cut off after 15 edges
	always @(posedge aclk) begin
		ext_ack_in <= 1'h0;
		if (go && !busy) begin
			cycle <= req;
			busy <= 1'h1;
			cnt <= 0;
			sel_seen <= 4'hf;
			err_seen <= 1'h0;
		end else if (busy && cycle.strobe) begin
			cnt <= cnt + 1;
			if (!(&select_n)) sel_seen <= select_n;
			if (berr_out) err_seen <= 1'h1;
			// answer only where the device leaves the acknowledge to us
			if (!ack_oe && !(&select_n) && cnt >= ext_wait) ext_ack_in <= 1'h1;
			if (ack_out || ext_ack_in || cnt == 15) begin
				lat <= cnt;
				cycle.strobe <= 1'h0;
				cycle.addr <= ~cycle.addr; // released lines do not keep their value
			end
		end else begin
			busy <= 1'h0;
		end
	end
endmodule

// *** cs_decoder_props.sv ***
`timescale 1ns/100ps
module cs_decoder_props (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// watched ports
	input wire cs_pkg::cycle_t cycle,
	input wire logic [3:0] select_n,
	input wire logic ack_out,
	input wire logic ack_oe,
	input wire logic berr_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// a select begins and the device owns the acknowledge
	sequence sel_start;
		$fell(&select_n) ##0 ack_oe;
	endsequence
	sequence ack_or_end;
		ack_out || !cycle.strobe;
	endsequence
	a_one_select: assert property ($onehot0(~select_n))
		else $error("more than one select low");
	a_idle_clear: assert property (!cycle.strobe |=> &select_n && !ack_out && !berr_out)
		else $error("outputs stand after strobe low");
	a_space_never: assert property (cycle.strobe && cycle.space == 3'h7 && &select_n |=> &select_n)
		else $error("select on reserved space");
	a_ack_owned: assert property (ack_out |-> ack_oe && !(&select_n))
		else $error("acknowledge without select or drive");
	a_wait_bound: assert property (sel_start |-> ##[0:7] ack_or_end)
		else $error("acknowledge later than seven waits");
	a_sel_steady: assert property (!(&select_n) && cycle.strobe |=> $stable(select_n))
		else $error("select moved within a cycle");
	a_ack_stands: assert property (ack_out && cycle.strobe |=> ack_out)
		else $error("acknowledge dropped early");
	a_sel_cause: assert property ($fell(&select_n) |-> $past(cycle.strobe))
		else $error("select without strobe");
	a_berr_write: assert property ($rose(berr_out) |-> $past(cycle.write) && cycle.strobe)
		else $error("bus error not on a write");
endmodule
bind chip_select_wait_state_decoder cs_decoder_props i_cs_decoder_props (.aclk(aclk),
	.aresetn(aresetn), .cycle(cycle), .select_n(select_n), .ack_out(ack_out),
	.ack_oe(ack_oe), .berr_out(berr_out));

// *** cs_pkg.sv ***
package cs_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] base_off = 8'h00; // select_base 0..3 at 0x00..0x0c
	localparam logic [7:0] option_off = 8'h10; // select_option 0..3 at 0x10..0x1c
	localparam logic [7:0] ctl_off = 8'h20; // system_control_word control bits
	localparam logic [7:0] stat_off = 8'h24; // system_control_word status bits
	localparam int num_sel = 4;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int fld_space_hi = 15;
	localparam int fld_space_lo = 13;
	localparam int fld_addr_hi = 12;
	localparam int fld_addr_lo = 2;
	localparam int fld_dir = 1; // direction bit (base) / direction_ignore_ctl (option)
	localparam int fld_en = 0; // enable (base) / space_compare_on (option)
	localparam int ctl_err_on = 0; // protect_violation_err_on
	localparam int ctl_extra_wait = 1; // outside_master_extra_wait
	localparam int stat_violation = 0; // protect_violation_flag

	// ----------------------------------------
	// reset values and codes
	// ----------------------------------------
	localparam logic [15:0] base_rst = 16'hc000; // space 110, addr 0, read only, off
	localparam logic [15:0] option_rst = 16'hdffd; // six waits, 8K mask, dir ignored, space compare on
	localparam logic [2:0] ack_external = 3'b111;
	localparam logic [2:0] space_never = 3'b111;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;

	// ----------------------------------------
	// bus cycle seen by the decoder
	// ----------------------------------------
	typedef struct packed {
		logic strobe; // address strobe, level, high for the whole cycle
		logic write; // 1 write, 0 read
		logic outside; // cycle run by an external master
		logic [2:0] space; // function code lines
		logic [23:0] addr;
	} cycle_t;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_wait = 3'b010,
		st_hold = 3'b100
	} state_t;
endpackage
